//--- include/htc_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface htc_conv_if;
	import htc_pkg::*;
	logic [2:0]          rate;
	logic                kick;
	logic [1:0]          chan;
	logic [1:0]          thermal_resolution;
	logic [1:0]          moisture_resolution;
	logic                done;
	logic                busy;
	logic [RESULT_W-1:0] temp;
	logic [RESULT_W-1:0] hum;

	modport ctl (output rate, kick, chan, thermal_resolution, moisture_resolution, input done, busy, temp, hum);
	modport eng (input rate, kick, chan, thermal_resolution, moisture_resolution, output done, busy, temp, hum);
endinterface : htc_conv_if
`default_nettype wire

//--- include/htc_pkg.sv
`default_nettype none
package htc_pkg;

	// =========================================================
	// Clock and sample periods
	localparam int unsigned CLK_HZ    = 20_000_000;
	localparam int unsigned MS_PER_S  = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int unsigned PER_W     = 17;

	localparam logic [PER_W-1:0] PER_2MIN_MS  = 17'd120000;
	localparam logic [PER_W-1:0] PER_1MIN_MS  = 17'd60000;
	localparam logic [PER_W-1:0] PER_10S_MS   = 17'd10000;
	localparam logic [PER_W-1:0] PER_5S_MS    = 17'd5000;
	localparam logic [PER_W-1:0] PER_1HZ_MS   = 17'd1000;
	localparam logic [PER_W-1:0] PER_2HZ_MS   = 17'd500;
	localparam logic [PER_W-1:0] PER_5HZ_MS   = 17'd200;

	// =========================================================
	// Register indices; byte address is four times the index
	localparam int unsigned IDX_W = 6;
	localparam logic [IDX_W-1:0] IDX_TEMP_LO  = 6'h00;
	localparam logic [IDX_W-1:0] IDX_TEMP_HI  = 6'h01;
	localparam logic [IDX_W-1:0] IDX_HUM_LO   = 6'h02;
	localparam logic [IDX_W-1:0] IDX_HUM_HI   = 6'h03;
	localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h0E;
	localparam logic [IDX_W-1:0] IDX_ACQ      = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h10;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 6'h11;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 6'h12;

	// =========================================================
	// Control register fields
	localparam int unsigned CTL_RESTART = 7;
	localparam int unsigned CTL_RATE_HI = 6;
	localparam int unsigned CTL_RATE_LO = 4;
	localparam int unsigned CTL_HEAT    = 3;
	localparam int unsigned CTL_DRIVE   = 2;
	localparam int unsigned CTL_LEVEL   = 1;
	localparam int unsigned CTL_MODE    = 0;
	localparam logic [7:0]  CTRL_RST    = 8'h00;

	// Acquisition register fields
	localparam int unsigned ACQ_THERMAL_RESOLUTION_HI = 7;
	localparam int unsigned ACQ_THERMAL_RESOLUTION_LO = 6;
	localparam int unsigned ACQ_MOISTURE_RESOLUTION_HI = 5;
	localparam int unsigned ACQ_MOISTURE_RESOLUTION_LO = 4;
	localparam int unsigned ACQ_CHAN_HI = 2;
	localparam int unsigned ACQ_CHAN_LO = 1;
	localparam int unsigned ACQ_KICK    = 0;
	localparam logic [7:0]  ACQ_RST     = 8'h00;
	localparam logic [7:0]  ACQ_WMASK   = 8'hFF;

	// Interrupt bits
	localparam int unsigned IRQ_N       = 3;
	localparam int unsigned IRQ_DONE    = 0;
	localparam int unsigned IRQ_THRESH  = 1;
	localparam int unsigned IRQ_RESTART = 2;

	// =========================================================
	// Codes
	localparam logic [2:0] RATE_OFF  = 3'h0;
	localparam logic [1:0] RES_14    = 2'h0;
	localparam logic [1:0] RES_11    = 2'h1;
	localparam logic [1:0] RES_8     = 2'h2;
	localparam logic [1:0] CH_BOTH   = 2'h0;
	localparam logic [1:0] CH_TEMP   = 2'h1;
	localparam logic [1:0] CH_HUM    = 2'h2;
	localparam int unsigned SAMPLE_W = 14;
	localparam int unsigned RESULT_W = 16;
	localparam logic [1:0]  RES_PAD  = 2'h0;
	localparam logic [SAMPLE_W-1:0] MASK_14 = 14'h3FFF;
	localparam logic [SAMPLE_W-1:0] MASK_11 = 14'h3FF8;
	localparam logic [SAMPLE_W-1:0] MASK_8  = 14'h3FC0;

	typedef enum logic [1:0] {
		HTC_IDLE,
		HTC_CONV_T,
		HTC_CONV_H
	} htc_state_e;

endpackage : htc_pkg
`default_nettype wire

//--- rtl/htc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module htc_engine
	import htc_pkg::*;
#(
	parameter int unsigned MS_CYC   = MS_CYCLES,
	parameter int unsigned CONV_CYC = 64
) (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                nrst,
	// Front-end samples
	input  wire logic [SAMPLE_W-1:0] afe_temp,
	input  wire logic [SAMPLE_W-1:0] afe_hum,
	// Control side
	htc_conv_if.eng                  cv
);

	logic [31:0]      ms_cnt;
	logic             ms_tick;
	logic [PER_W-1:0] per_cnt;
	logic [PER_W-1:0] per_len;
	logic             auto_tick;
	logic [31:0]      conv_cnt;
	htc_state_e       state;

	function automatic logic [RESULT_W-1:0] trim(input logic [SAMPLE_W-1:0] v,
	                                              input logic [1:0] res);
		logic [SAMPLE_W-1:0] m;
		unique case (res)
			RES_11:  m = MASK_11;
			RES_8:   m = MASK_8;
			default: m = MASK_14;
		endcase
		return {v & m, RES_PAD};
	endfunction : trim

	// =========================================================
	// Periodic sampling
	always_comb begin
		unique case (cv.rate)
			3'h1:    per_len = PER_2MIN_MS;
			3'h2:    per_len = PER_1MIN_MS;
			3'h3:    per_len = PER_10S_MS;
			3'h4:    per_len = PER_5S_MS;
			3'h5:    per_len = PER_1HZ_MS;
			3'h6:    per_len = PER_2HZ_MS;
			default: per_len = PER_5HZ_MS;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst || cv.rate == RATE_OFF || ms_tick) begin
			ms_cnt <= '0;
		end else begin
			ms_cnt <= ms_cnt + 32'd1;
		end
	end
	assign ms_tick = (ms_cnt == MS_CYC - 1);

	always_ff @(posedge mclk) begin
		if (!nrst || cv.rate == RATE_OFF) begin
			per_cnt <= '0;
		end else if (ms_tick) begin
			per_cnt <= (per_cnt >= per_len - 17'd1) ? '0 : per_cnt + 17'd1;
		end
	end
	assign auto_tick = ms_tick && (per_cnt >= per_len - 17'd1) && cv.rate != RATE_OFF;

	// =========================================================
	// Conversion sequence
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state    <= HTC_IDLE;
			conv_cnt <= '0;
			cv.temp  <= '0;
			cv.hum   <= '0;
			cv.done  <= 1'b0;
		end else begin
			cv.done <= 1'b0;
			unique case (state)
				HTC_IDLE: begin
					conv_cnt <= '0;
					if (cv.kick || auto_tick) begin
						state <= (cv.chan == CH_HUM) ? HTC_CONV_H : HTC_CONV_T;
					end
				end
				HTC_CONV_T: begin
					conv_cnt <= conv_cnt + 32'd1;
					if (conv_cnt == CONV_CYC - 1) begin
						conv_cnt <= '0;
						cv.temp  <= trim(afe_temp, cv.thermal_resolution);
						if (cv.chan == CH_TEMP) begin
							state   <= HTC_IDLE;
							cv.done <= 1'b1;
						end else begin
							state <= HTC_CONV_H;
						end
					end
				end
				HTC_CONV_H: begin
					conv_cnt <= conv_cnt + 32'd1;
					if (conv_cnt == CONV_CYC - 1) begin
						cv.hum  <= trim(afe_hum, cv.moisture_resolution);
						state   <= HTC_IDLE;
						cv.done <= 1'b1;
					end
				end
			endcase
		end
	end
	assign cv.busy = (state != HTC_IDLE);

endmodule : htc_engine
`default_nettype wire

//--- rtl/htc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module htc_regs
	import htc_pkg::*;
#(
	parameter int unsigned MS_CYC   = MS_CYCLES,
	parameter int unsigned CONV_CYC = 64
) (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                nrst,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Front end and threshold compare
	input  wire logic [SAMPLE_W-1:0] afe_temp,
	input  wire logic [SAMPLE_W-1:0] afe_hum,
	input  wire logic                thresh_hit,
	// Alert pin
	output logic                     alert_o,
	output logic                     alert_oe,
	// Status outputs
	output logic                     warming_element_on,
	output logic                     irq
);

	htc_conv_if cv ();

	logic [7:0]       ctrl;
	logic [7:0]       acq;
	logic             restart;
	logic             req;
	logic             wr;
	logic             rd;
	logic [IDX_W-1:0] idx;
	logic [31:0]      next_rdata;
	logic [IRQ_N-1:0] irq_stat;
	logic [IRQ_N-1:0] irq_en;
	logic [IRQ_N-1:0] irq_set;
	logic [IRQ_N-1:0] irq_clr;
	logic             thresh_q;
	logic             thresh_rise;
	logic             alert_latch;
	logic             ready_flag;
	logic             result_rd;
	logic             next_assert;
	logic             nrst_eng;

	// =========================================================
	// Bus decode
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx = wb_adr_i[7:2];
	assign wr  = req && wb_we_i && wb_sel_i[0];
	assign rd  = req && !wb_we_i;
	assign result_rd = rd && (idx == IDX_TEMP_LO || idx == IDX_TEMP_HI ||
	                          idx == IDX_HUM_LO || idx == IDX_HUM_HI);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// =========================================================
	// Restart: one cycle pulse, register bit itself reads zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			restart <= 1'b0;
		end else begin
			restart <= wr && idx == IDX_CTRL && wb_dat_i[CTL_RESTART];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			nrst_eng <= 1'b0;
		end else begin
			nrst_eng <= !(wr && idx == IDX_CTRL && wb_dat_i[CTL_RESTART]);
		end
	end

	// =========================================================
	// Control register
	always_ff @(posedge mclk) begin
		if (!nrst || restart) begin
			ctrl <= CTRL_RST;
		end else if (wr && idx == IDX_CTRL && !wb_dat_i[CTL_RESTART]) begin
			ctrl <= wb_dat_i[7:0];
			ctrl[CTL_RESTART] <= 1'b0;
		end
	end

	// =========================================================
	// Acquisition register; kick set by write, cleared on completion
	always_ff @(posedge mclk) begin
		if (!nrst || restart) begin
			acq <= ACQ_RST;
		end else if (wr && idx == IDX_ACQ) begin
			// A pending kick survives the write unless completion lands in the same cycle
			acq <= (wb_dat_i[7:0] & ACQ_WMASK) | {7'h00, acq[ACQ_KICK] && !cv.done};
		end else if (cv.done) begin
			acq[ACQ_KICK] <= 1'b0;
		end
	end

	// Kick pulse reaches the engine one cycle after the write
	always_ff @(posedge mclk) begin
		if (!nrst || restart) begin
			cv.kick <= 1'b0;
		end else begin
			cv.kick <= wr && idx == IDX_ACQ && wb_dat_i[ACQ_KICK];
		end
	end

	assign cv.rate = ctrl[CTL_RATE_HI:CTL_RATE_LO];
	assign cv.thermal_resolution = acq[ACQ_THERMAL_RESOLUTION_HI:ACQ_THERMAL_RESOLUTION_LO];
	assign cv.moisture_resolution = acq[ACQ_MOISTURE_RESOLUTION_HI:ACQ_MOISTURE_RESOLUTION_LO];
	assign cv.chan = acq[ACQ_CHAN_HI:ACQ_CHAN_LO];

	htc_engine #(
		.MS_CYC   (MS_CYC),
		.CONV_CYC (CONV_CYC)
	) u_engine (
		.mclk     (mclk),
		.nrst     (nrst && nrst_eng),
		.afe_temp (afe_temp),
		.afe_hum  (afe_hum),
		.cv       (cv)
	);

	// =========================================================
	// Warming element
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			warming_element_on <= 1'b0;
		end else begin
			warming_element_on <= ctrl[CTL_HEAT];
		end
	end

	// =========================================================
	// Alert pin: result-available and threshold share it
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			thresh_q <= 1'b0;
		end else begin
			thresh_q <= thresh_hit;
		end
	end
	assign thresh_rise = thresh_hit && !thresh_q;

	always_ff @(posedge mclk) begin
		if (!nrst || restart) begin
			ready_flag <= 1'b0;
		end else if (cv.done) begin
			ready_flag <= 1'b1;
		end else if (result_rd) begin
			ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst || restart) begin
			alert_latch <= 1'b0;
		end else if (cv.done || thresh_rise) begin
			alert_latch <= 1'b1;
		end else if (result_rd) begin
			alert_latch <= 1'b0;
		end
	end

	always_comb begin
		if (ctrl[CTL_MODE]) begin
			next_assert = ready_flag || thresh_hit;
		end else begin
			next_assert = alert_latch;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			alert_o  <= 1'b1;
			alert_oe <= 1'b0;
		end else begin
			alert_o  <= ctrl[CTL_LEVEL] ? next_assert : !next_assert;
			alert_oe <= ctrl[CTL_DRIVE];
		end
	end

	// =========================================================
	// Interrupt status, enable and clear
	assign irq_set = {restart, thresh_rise, cv.done};
	assign irq_clr = (wr && idx == IDX_IRQ_CLR) ? wb_dat_i[IRQ_N-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq_en <= '0;
		end else if (wr && idx == IDX_IRQ_EN) begin
			irq_en <= wb_dat_i[IRQ_N-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
		end
	end

	// =========================================================
	// Read data
	always_comb begin
		next_rdata = '0;
		unique case (idx)
			IDX_TEMP_LO:  next_rdata[7:0] = cv.temp[7:0];
			IDX_TEMP_HI:  next_rdata[7:0] = cv.temp[15:8];
			IDX_HUM_LO:   next_rdata[7:0] = cv.hum[7:0];
			IDX_HUM_HI:   next_rdata[7:0] = cv.hum[15:8];
			IDX_CTRL:     next_rdata[7:0] = ctrl;
			IDX_ACQ:      next_rdata[7:0] = acq;
			IDX_IRQ_STAT: next_rdata[IRQ_N-1:0] = irq_stat;
			IDX_IRQ_EN:   next_rdata[IRQ_N-1:0] = irq_en;
			default:      next_rdata = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wb_dat_o <= '0;
		end else if (rd) begin
			wb_dat_o <= next_rdata;
		end else begin
			wb_dat_o <= '0;
		end
	end

endmodule : htc_regs
`default_nettype wire

//--- tb/htc_host_pin.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host view of the alert pin
module htc_host_pin (
	input  wire logic mclk,
	input  wire logic alert_o,
	input  wire logic alert_oe,
	output var  logic pin
);
	logic float_v = 1'b0;

	// Undriven pin wanders so a stale level never passes
	always_ff @(posedge mclk) float_v <= !float_v;
	assign pin = alert_oe ? alert_o : float_v;
endmodule : htc_host_pin
`default_nettype wire

//--- tb/htc_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus and pin checks
module htc_regs_assertions
	import htc_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Pins
	input wire logic        alert_oe,
	input wire logic        warming_element_on
);
	logic             take;
	logic             rd_ack;
	logic [IDX_W-1:0] idx;

	assign take   = wb_cyc_i & wb_stb_i & !wb_ack_o;
	assign rd_ack = wb_ack_o & !wb_we_i;
	assign idx    = wb_adr_i[7:2];

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_ctrl_wr;
		take && wb_we_i && wb_sel_i[0] && idx == IDX_CTRL;
	endsequence
	sequence s_cfg_wr;
		s_ctrl_wr ##0 !wb_dat_i[CTL_RESTART];
	endsequence

	chk_ack_one_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	chk_idle_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_read_upper_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	chk_restart_reads_zero: assert property (
		rd_ack && idx == IDX_CTRL |-> !wb_dat_o[CTL_RESTART])
		else $error("restart bit reads one");
	chk_result_pad_zero: assert property (
		rd_ack && (idx == IDX_TEMP_LO || idx == IDX_HUM_LO) |-> wb_dat_o[1:0] == RES_PAD)
		else $error("result pad bits not zero");
	chk_heat_follows_bit: assert property (
		s_cfg_wr |-> ##2 warming_element_on == $past(wb_dat_i[CTL_HEAT], 2))
		else $error("heater output wrong");
	chk_drive_follows_bit: assert property (
		s_cfg_wr |-> ##2 alert_oe == $past(wb_dat_i[CTL_DRIVE], 2))
		else $error("pin enable wrong");
	chk_restart_clears_pins: assert property (
		s_ctrl_wr ##0 wb_dat_i[CTL_RESTART] |-> ##3 !warming_element_on && !alert_oe)
		else $error("restart left pins set");
	chk_reset_pin_state: assert property (
		$rose(nrst) |-> !wb_ack_o && !alert_oe && !warming_element_on)
		else $error("outputs wrong after reset");
endmodule : htc_regs_assertions

bind htc_regs htc_regs_assertions i_chk (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .alert_oe, .warming_element_on);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register block bench
module tb;
	import htc_pkg::*;
	typedef struct {
		logic [7:0] a;
		logic [7:0] w;
		logic [7:0] r;
		logic       h;
		logic       o;
	} htc_row_s;

	logic        mclk, nrst, cyc, stb, we, ack, thr, ao, aoe, heat, irq, pin;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dw, dr;
	logic [13:0] at, ah;
	int          miscompares, checks_done;
	htc_row_s    rows [8] = '{'{8'h38, 8'h08, 8'h08, 1'b1, 1'b0},
		'{8'h38, 8'h04, 8'h04, 1'b0, 1'b1}, '{8'h38, 8'h06, 8'h06, 1'b0, 1'b1},
		'{8'h38, 8'h01, 8'h01, 1'b0, 1'b0}, '{8'h3C, 8'h6A, 8'h6A, 1'b0, 1'b0},
		'{8'h3C, 8'h98, 8'h98, 1'b0, 1'b0}, '{8'h7C, 8'hFF, 8'h00, 1'b0, 1'b0},
		'{8'h38, 8'h70, 8'h70, 1'b0, 1'b0}};

	htc_regs #(.MS_CYC(10), .CONV_CYC(4)) i_dut (.mclk(mclk), .nrst(nrst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .afe_temp(at), .afe_hum(ah),
		.thresh_hit(thr), .alert_o(ao), .alert_oe(aoe), .warming_element_on(heat),
		.irq(irq));
	htc_host_pin i_host (.mclk(mclk), .alert_o(ao), .alert_oe(aoe), .pin(pin));

	// ==========
	// Tasks
	task automatic conclude();
		$display("Checks %0d, errors %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: register %h, expected %h", $time, g, e);
		end
	endtask : cmp_reg

	task automatic cmp_pin(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: signal %b, expected %b", $time, g, e);
		end
	endtask : cmp_pin

	task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'h1;
		dw  <= {24'h0, d};
		do @(posedge mclk); while (ack !== 1'b1);
		q = dr[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		wb(1'b0, a, 8'h00, q);
	endtask : rd

	task automatic settle();
		repeat (3) @(posedge mclk);
	endtask : settle

	// Kick one conversion and check the four result bytes
	task automatic conv(input logic [7:0] c, tl, tm, hl, hm);
		logic [7:0] q;
		wr(8'h3C, c);
		rd(8'h3C, q);
		cmp_pin(q[ACQ_KICK], 1'b1);
		cmp_pin(pin, 1'b0);
		while (q[ACQ_KICK] !== 1'b0) rd(8'h3C, q);
		settle();
		cmp_pin(pin, 1'b1);
		rd(8'h00, q);
		cmp_reg(q, tl);
		rd(8'h04, q);
		cmp_reg(q, tm);
		rd(8'h08, q);
		cmp_reg(q, hl);
		rd(8'h0C, q);
		cmp_reg(q, hm);
		settle();
		cmp_pin(pin, 1'b0);
	endtask : conv

	// ==========
	// Clock, watchdog and sequence
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		conclude();
	end

	initial begin
		logic [7:0] q;
		int         n;
		{nrst, cyc, stb, we, thr, adr, sel, dw, at, ah} = '0;
		miscompares = 0;
		checks_done = 0;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		rd(8'h38, q);
		cmp_reg(q, CTRL_RST);
		rd(8'h3C, q);
		cmp_reg(q, ACQ_RST);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, q);
			cmp_reg(q, rows[i].r);
			cmp_pin(heat, rows[i].h);
			cmp_pin(aoe, rows[i].o);
		end
		wr(8'h38, 8'h04);
		settle();
		cmp_pin(pin, 1'b1);
		wr(8'h38, 8'h06);
		settle();
		cmp_pin(pin, 1'b0);
		at <= 14'h3FFF;
		ah <= 14'h2AAB;
		conv(8'h01, 8'hFC, 8'hFF, 8'hAC, 8'hAA);
		ah <= 14'h0000;
		conv(8'h93, 8'h00, 8'hFF, 8'hAC, 8'hAA);
		at <= 14'h0000;
		ah <= 14'h2AAB;
		conv(8'h15, 8'h00, 8'hFF, 8'hA0, 8'hAA);
		// Comparator then latched alert, interrupt masked then enabled
		wr(8'h44, 8'h07);
		wr(8'h38, 8'h07);
		thr <= 1'b1;
		settle();
		cmp_pin(pin, 1'b1);
		cmp_pin(irq, 1'b0);
		thr <= 1'b0;
		settle();
		cmp_pin(pin, 1'b0);
		wr(8'h38, 8'h06);
		rd(8'h00, q);
		settle();
		cmp_pin(pin, 1'b0);
		thr <= 1'b1;
		settle();
		thr <= 1'b0;
		settle();
		cmp_pin(pin, 1'b1);
		rd(8'h00, q);
		settle();
		cmp_pin(pin, 1'b0);
		rd(8'h40, q);
		cmp_reg(q, 8'h02);
		wr(8'h48, 8'h02);
		settle();
		cmp_pin(irq, 1'b1);
		wr(8'h44, 8'h02);
		settle();
		cmp_pin(irq, 1'b0);
		// Soft restart
		wr(8'h38, 8'h0E);
		wr(8'h3C, 8'h98);
		wr(8'h38, 8'h8E);
		rd(8'h38, q);
		cmp_reg(q, CTRL_RST);
		rd(8'h3C, q);
		cmp_reg(q, ACQ_RST);
		rd(8'h04, q);
		cmp_reg(q, 8'h00);
		cmp_pin(heat, 1'b0);
		cmp_pin(aoe, 1'b0);
		rd(8'h40, q);
		cmp_reg(q, 8'h04);
		// Periodic sampling: none when off, 200 ms apart at the fastest code
		wr(8'h44, 8'h07);
		wr(8'h48, 8'h01);
		repeat (2500) @(posedge mclk);
		cmp_pin(irq, 1'b0);
		wr(8'h38, 8'h70);
		n = 0;
		while (irq !== 1'b1 && n < 2500) begin
			@(posedge mclk);
			n++;
		end
		cmp_pin(irq, 1'b1);
		wr(8'h44, 8'h01);
		settle();
		n = 0;
		while (irq !== 1'b1 && n < 2500) begin
			@(posedge mclk);
			n++;
		end
		cmp_pin(n > 1980 && n < 2010, 1'b1);
		// Mid-run reset
		wr(8'h38, 8'h0E);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		cmp_pin(heat, 1'b0);
		cmp_pin(aoe, 1'b0);
		rd(8'h38, q);
		cmp_reg(q, CTRL_RST);
		conclude();
	end
endmodule : tb
`default_nettype wire
